// ===== hdl/lhf_map.vh
`ifndef LHF_MAP_VH
`define LHF_MAP_VH
// ----------------------------------------
// Poll counter
// ----------------------------------------
`define LHF_CNT_W        13
`define LHF_POLL_COUNT   13'h1000
// ----------------------------------------
// Clock source codes on the source mux
// ----------------------------------------
`define LHF_SRC_OSC      2'h0
`define LHF_SRC_SEC      2'h1
`define LHF_SRC_PLL      2'h2
// ----------------------------------------
// Reset values
// ----------------------------------------
`define LHF_RST_FLAG     1'h0
`define LHF_RST_IRQ      1'h0
`define LHF_RST_SEL      2'h0
`endif

// ===== hdl/lhf_sel_sync.v
`timescale 1ns/1ns
`include "lhf_map.vh"
// ----------------------------------------
// Glitch-free select handover
// ----------------------------------------
// The active select changes in the same cycle that the old source is parked:
// the new code is held one cycle with every source disabled, so a
// downstream clock gate never sees a truncated phase.
module lhf_sel_sync (
    input  wire       clk,      // System clock
    input  wire       nrst,     // Sync reset, active low
    input  wire [1:0] sel_req,  // Requested source code
    output reg  [1:0] sel_q,    // Source code in effect
    output reg        gate_q    // High while selected source may run
);
    // Park for one cycle on every change of request
    always @(posedge clk) begin
        if (!nrst) begin
            sel_q  <= `LHF_RST_SEL;
            gate_q <= 1'b0;
        end else if (sel_req != sel_q) begin
            sel_q  <= sel_req;
            gate_q <= 1'b0;
        end else begin
            gate_q <= 1'b1;
        end
    end
endmodule

// ===== hdl/lhf_clock_fallback.v
`timescale 1ns/1ns
`include "lhf_map.vh"
module lhf_clock_fallback (
    input  wire       clk,                       // System clock, 100 MHz
    input  wire       nrst,                      // Sync reset, active low
    input  wire       slow_tick,                 // Slow reference clock enable pulse
    input  wire       ext_clk_ok,                // Monitor: external clock present
    input  wire       clk_missing,               // Monitor: external clock lost
    input  wire       pll_power_on,              // Programmed PLL power
    input  wire       bus_clk_pll_select,        // Programmed bus PLL select
    input  wire       bus_clk_secondary_select,  // Programmed secondary select
    input  wire       module_clk_select,         // Programmed module select
    input  wire       clk_monitor_enable,        // Programmed monitor enable
    input  wire       forced_clk_monitor_enable, // Programmed forced monitor enable
    input  wire       can_clk_select,            // Programmed CAN clock select
    input  wire       fallback_irq_enable,       // Interrupt enable
    input  wire       fallback_irq_clear,        // Software clear pulse
    output reg        fallback_mode_flag,        // Status flag
    output reg        fallback_irq_flag,         // Sticky irq flag
    output reg        fallback_irq_req,          // Interrupt request
    output reg        pll_power_on_eff,          // PLL power in effect
    output reg        bus_pll_sel_eff,           // Bus PLL select in effect
    output reg        module_sel_eff,            // Module select in effect
    output reg        monitor_en_eff,            // Monitor enable in effect
    output reg        can_clk_sel_eff,           // CAN select, untouched
    output reg  [1:0] sys_src_q,                 // System clock source
    output reg        sys_gate_q,                // System clock gate
    output reg  [1:0] slow_src_q,                // Slow ref/debug source
    output reg  [1:0] mod_src_q,                 // Module clock source
    output reg  [1:0] ebus_src_q,                // External bus clock source
    output reg        poll_q                     // One-cycle poll strobe
);

    // ----------------------------------------
    // Input synchronisers
    // ----------------------------------------
    reg  [2:0] s1_q;
    reg  [2:0] s2_q;
    reg        tick_prev_q;
    wire       tick_rise;
    wire       ok_s;
    wire       miss_s;

    // Monitor and tick come from other domains
    // Only second stage is read: a metastable
    // first stage never reaches counter or mode
    always @(posedge clk) begin
        if (!nrst) begin
            s1_q        <= 3'h0;
            s2_q        <= 3'h0;
            tick_prev_q <= 1'b0;
        end else begin
            s1_q        <= {slow_tick, ext_clk_ok, clk_missing};
            s2_q        <= s1_q;
            tick_prev_q <= s2_q[2];
        end
    end
    assign tick_rise = s2_q[2] & ~tick_prev_q;
    assign ok_s      = s2_q[1];
    assign miss_s    = s2_q[0];

    // ----------------------------------------
    // Free-running poll counter
    // ----------------------------------------
    reg  [`LHF_CNT_W-1:0] cnt_q;
    wire                  poll_hit;

    // Wraps every 8192 ticks, so the monitor is checked once per wrap
    always @(posedge clk) begin
        if (!nrst)
            cnt_q <= {`LHF_CNT_W{1'b0}};
        else if (tick_rise)
            cnt_q <= cnt_q + 13'h1;
    end
    assign poll_hit = tick_rise && (cnt_q == (`LHF_POLL_COUNT - 13'h1));

    // ----------------------------------------
    // Fallback state and flags
    // ----------------------------------------
    reg  mode_d;
    reg  irq_d;

    // Entry on loss is immediate; exit waits for a poll
    always @* begin
        mode_d = fallback_mode_flag;
        if (!fallback_mode_flag && miss_s)
            mode_d = 1'b1;
        else if (fallback_mode_flag && poll_hit && ok_s)
            mode_d = 1'b0;
        irq_d = fallback_irq_flag;
        if (fallback_irq_clear)
            irq_d = 1'b0;
        if (mode_d != fallback_mode_flag)
            irq_d = 1'b1;
    end

    always @(posedge clk) begin
        if (!nrst) begin
            fallback_mode_flag <= `LHF_RST_FLAG;
            fallback_irq_flag  <= `LHF_RST_IRQ;
            fallback_irq_req   <= 1'b0;
        end else begin
            fallback_mode_flag <= mode_d;
            fallback_irq_flag  <= irq_d;
            fallback_irq_req   <= irq_d & fallback_irq_enable;
        end
    end

    // ----------------------------------------
    // Poll strobe
    // ----------------------------------------
    // Registered poll, one cycle late; exit lines up with it
    always @(posedge clk) begin
        if (!nrst)
            poll_q <= 1'b0;
        else
            poll_q <= poll_hit;
    end

    // ----------------------------------------
    // Forced controls
    // ----------------------------------------
    // Forcing ends as soon as the flag drops, restoring programmed bits
    // CAN select only re-timed, never forced
    always @(posedge clk) begin
        if (!nrst) begin
            pll_power_on_eff <= 1'b0;
            bus_pll_sel_eff  <= 1'b0;
            module_sel_eff   <= 1'b0;
            monitor_en_eff   <= 1'b0;
            can_clk_sel_eff  <= 1'b0;
        end else begin
            pll_power_on_eff <= mode_d | pll_power_on;
            bus_pll_sel_eff  <= mode_d | bus_clk_pll_select;
            module_sel_eff   <= ~mode_d & module_clk_select;
            monitor_en_eff   <= mode_d | clk_monitor_enable
                                | forced_clk_monitor_enable;
            can_clk_sel_eff  <= can_clk_select;
        end
    end

    // ----------------------------------------
    // Source selection
    // ----------------------------------------
    function [1:0] bus_src;
        input pll_sel;
        input sec_sel;
        begin
            if (pll_sel)
                bus_src = `LHF_SRC_PLL;
            else if (sec_sel)
                bus_src = `LHF_SRC_SEC;
            else
                bus_src = `LHF_SRC_OSC;
        end
    endfunction

    // Fallback overrides a derived source with the PLL
    function [1:0] fb_src;
        input       fb;
        input [1:0] alt;
        begin
            if (fb)
                fb_src = `LHF_SRC_PLL;
            else
                fb_src = alt;
        end
    endfunction

    wire [1:0] sys_req;
    wire [1:0] sys_sel;
    wire       sys_gate;

    assign sys_req = bus_src(mode_d | bus_clk_pll_select, bus_clk_secondary_select);

    lhf_sel_sync u_sys_sel (
        .clk     (clk),
        .nrst    (nrst),
        .sel_req (sys_req),
        .sel_q   (sys_sel),
        .gate_q  (sys_gate)
    );

    // System select, parked by the handover stage in the same cycle it moves
    always @(posedge clk) begin
        if (!nrst) begin
            sys_src_q  <= `LHF_RST_SEL;
            sys_gate_q <= 1'b0;
        end else begin
            sys_src_q  <= sys_sel;
            sys_gate_q <= sys_gate;
        end
    end

    // ----------------------------------------
    // Derived clock sources
    // ----------------------------------------
    // Follow the PLL while in fallback; not parked here,
    // so each downstream gate must hold across a switch
    always @(posedge clk) begin
        if (!nrst) begin
            slow_src_q <= `LHF_RST_SEL;
            mod_src_q  <= `LHF_RST_SEL;
            ebus_src_q <= `LHF_RST_SEL;
        end else begin
            slow_src_q <= fb_src(fallback_mode_flag, `LHF_SRC_OSC);
            mod_src_q  <= fb_src(fallback_mode_flag | module_clk_select,
                                 `LHF_SRC_OSC);
            ebus_src_q <= fb_src(fallback_mode_flag, sys_sel);
        end
    end
endmodule

// ===== tb/lhf_ext_src.sv
`timescale 1ns/1ns
// Reference source model; the monitor lags the source by one cycle
module lhf_ext_src (
    input  wire clk,                // Clock
    input  wire present,            // Source alive
    output reg  slow_tick   = 1'b0, // Slow clock
    output reg  ext_clk_ok  = 1'b1, // Present
    output reg  clk_missing = 1'b0  // Lost
);
    // Slow clock never stops, so poll spacing stays measurable
    always @(posedge clk) begin
        slow_tick   <= ~slow_tick;
        ext_clk_ok  <= present;
        clk_missing <= ~present;
    end
endmodule

// ===== tb/lhf_clock_fallback_chk.sv
`timescale 1ns/1ns
`include "lhf_map.vh"
module lhf_clock_fallback_chk (
    input wire       clk,                 // Clock
    input wire       nrst,                // Reset
    input wire       slow_tick,           // Tick
    input wire       fallback_irq_enable, // Enable
    input wire       fallback_irq_clear,  // Clear
    input wire       fallback_mode_flag,  // Mode
    input wire       fallback_irq_flag,   // Flag
    input wire       fallback_irq_req,    // Request
    input wire       pll_power_on_eff,    // Power
    input wire       bus_pll_sel_eff,     // Bus
    input wire       module_sel_eff,      // Module
    input wire       monitor_en_eff,      // Monitor
    input wire [1:0] sys_src_q,           // Source
    input wire       sys_gate_q,          // Gate
    input wire       poll_q               // Poll
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);
    // Tick rises since the last poll; too long for a repetition
    reg        tk_q   = 1'b0;
    reg        seen_q = 1'b0;
    reg [15:0] rise_q = 16'h0;
    always @(posedge clk) begin
        tk_q   <= slow_tick;
        seen_q <= nrst & (seen_q | poll_q);
        rise_q <= (poll_q ? 16'h0 : rise_q) + {15'h0, slow_tick & ~tk_q};
    end
    // Forcing, source and flag relations
    property p_force;
        fallback_mode_flag |-> pll_power_on_eff && bus_pll_sel_eff && !module_sel_eff
            && monitor_en_eff;
    endproperty
    a_force: assert property (p_force) else $error("not forced");
    property p_sys;
        fallback_mode_flag [*4] |-> sys_src_q == `LHF_SRC_PLL && sys_gate_q;
    endproperty
    a_sys: assert property (p_sys) else $error("not on vco");
    property p_glitch; $changed(sys_src_q) |-> !sys_gate_q || !$past(sys_gate_q); endproperty
    a_glitch: assert property (p_glitch) else $error("switch ungated");
    property p_set; $changed(fallback_mode_flag) |-> fallback_irq_flag; endproperty
    a_set: assert property (p_set) else $error("irq flag not set");
    property p_req;
        $past(nrst) |-> fallback_irq_req == (fallback_irq_flag && $past(fallback_irq_enable));
    endproperty
    a_req: assert property (p_req) else $error("request wrong");
    property p_hold;
        $past(nrst) && $past(fallback_irq_flag) && !$past(fallback_irq_clear)
            |-> fallback_irq_flag;
    endproperty
    a_hold: assert property (p_hold) else $error("irq flag lost");
    property p_exit; $fell(fallback_mode_flag) |-> poll_q || $past(poll_q); endproperty
    a_exit: assert property (p_exit) else $error("exit off poll");
    property p_poll; poll_q && seen_q |-> rise_q == 16'h2000; endproperty
    a_poll: assert property (p_poll) else $error("poll spacing");
    c_enter: cover property ($rose(fallback_mode_flag));
    c_exit: cover property ($fell(fallback_mode_flag));
    c_poll: cover property (poll_q && seen_q);
endmodule
bind lhf_clock_fallback lhf_clock_fallback_chk u_lhf_clock_fallback_chk (.*);

// ===== tb/lhf_clock_fallback_bench.sv
`timescale 1ns/1ns
`include "lhf_map.vh"
module lhf_clock_fallback_bench;
    reg        clk = 1'b0;
    reg        nrst = 1'b0;
    reg        present = 1'b1;
    reg        clr = 1'b0;
    reg  [7:0] pr = 8'h00; // Power, bus pll, bus sec, module, cme, forced_clk_monitor_enable, can, irq enable
    wire       tk, ok, ms, flg, irf, irq, pll, bps, msl, mon, can, gt, pl;
    wire [1:0] sy, sl, md, eb;
    integer    mismatches = 0;
    integer    n_checks = 0;
    integer    cyc = 0;
    integer    i, m_flag, m_irq;
    reg  [1:0] m_src = 2'h0;
    lhf_ext_src u_lhf_ext_src (.clk(clk), .present(present), .slow_tick(tk), .ext_clk_ok(ok),
        .clk_missing(ms));
    lhf_clock_fallback u_lhf_clock_fallback (.clk(clk), .nrst(nrst), .slow_tick(tk),
        .ext_clk_ok(ok), .clk_missing(ms), .pll_power_on(pr[7]), .bus_clk_pll_select(pr[6]),
        .bus_clk_secondary_select(pr[5]), .module_clk_select(pr[4]), .clk_monitor_enable(pr[3]),
        .forced_clk_monitor_enable(pr[2]), .can_clk_select(pr[1]), .fallback_irq_enable(pr[0]),
        .fallback_irq_clear(clr), .fallback_mode_flag(flg), .fallback_irq_flag(irf),
        .fallback_irq_req(irq), .pll_power_on_eff(pll), .bus_pll_sel_eff(bps),
        .module_sel_eff(msl), .monitor_en_eff(mon), .can_clk_sel_eff(can), .sys_src_q(sy),
        .sys_gate_q(gt), .slow_src_q(sl), .mod_src_q(md), .ebus_src_q(eb), .poll_q(pl));
    initial forever #5 clk = ~clk;
    task chk(input [1:0] got, input [1:0] exp);
        begin
            n_checks = n_checks + 1;
            if (got !== exp) begin
                mismatches = mismatches + 1;
                $display("MISMATCH at %0t: got %h want %h", $time, got, exp);
            end
        end
    endtask
    task results;
        begin
            $display("checks %0d mismatches %0d", n_checks, mismatches);
            if (mismatches == 0 && n_checks > 0)
                $display("No errors found");
            else
                $display("Errors were found");
            $finish;
        end
    endtask
    // Hang guard; the run needs about 25200 cycles
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 50000) begin
            mismatches = mismatches + 1;
            $display("MISMATCH at %0t: timeout", $time);
            results;
        end
    end
    // Main sequence; m_flag and m_irq model the status bits
    initial begin
        m_flag = 0;
        m_irq = 0;
        i = $urandom(32'h1e9a);
        repeat (20) @(posedge clk);
        #1 chk({flg, irf}, 2'b00);
        @(posedge clk) nrst <= 1'b1;
        for (i = 0; i < 8; i = i + 1) begin
            @(posedge clk) pr <= 8'($urandom);
            repeat (6) @(posedge clk);
            #1 chk({pll, bps}, pr[7:6]);
            chk({msl, can}, {pr[4], pr[1]});
            m_src = pr[6] ? `LHF_SRC_PLL : (pr[5] ? `LHF_SRC_SEC : `LHF_SRC_OSC);
            chk(sy, m_src);
            chk(eb, m_src);
            chk(md, pr[4] ? `LHF_SRC_PLL : `LHF_SRC_OSC);
            chk({mon, gt}, {pr[3] | pr[2], 1'b1});
        end
        $display("test passthrough done");
        @(posedge clk) pr <= 8'h33;
        present <= 1'b0;
        m_flag = 1;
        m_irq = 1;
        repeat (10) @(posedge clk);
        #1 chk({flg, irf}, {m_flag[0], m_irq[0]});
        chk({pll, bps}, 2'b11);
        chk({msl, mon}, 2'b01);
        chk({can, irq}, {pr[1], pr[0]});
        chk(sy, `LHF_SRC_PLL);
        chk(sl & md & eb, `LHF_SRC_PLL);
        @(posedge clk) clr <= 1'b1;
        @(posedge clk) clr <= 1'b0;
        m_irq = 0;
        repeat (3) @(posedge clk);
        #1 chk({irf, irq}, {m_irq[0], 1'b0});
        $display("test entry done");
        @(posedge clk) present <= 1'b1;
        for (i = 0; i < 20000 && flg !== 1'b0; i = i + 1)
            @(posedge clk);
        m_flag = 0;
        m_irq = 1;
        repeat (6) @(posedge clk);
        #1 chk({flg, irf}, {m_flag[0], m_irq[0]});
        chk({bps, msl}, {pr[6], pr[4]});
        chk(sy, `LHF_SRC_SEC);
        chk(eb, `LHF_SRC_SEC);
        chk(sl, `LHF_SRC_OSC);
        chk(md, `LHF_SRC_PLL);
        chk({irq, gt}, {m_irq[0] & pr[0], 1'b1});
        repeat (17000) @(posedge clk);
        $display("test exit done");
        results;
    end
endmodule
